// ===== src/prcps_pkg.sv
`default_nettype none

package prcps_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int ADDR_W     = 7;
    localparam int DATA_W     = 8;
    localparam int PAGE_COUNT = 38;
    localparam int PAGE_REGS  = 128;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [6:0] OFF_PAGE  = 7'h00;
    localparam logic [6:0] OFF_SWRST = 7'h01;
    localparam logic [6:0] OFF_RSV2  = 7'h02;
    localparam logic [6:0] OFF_RSV3  = 7'h03;
    localparam logic [6:0] OFF_MUX   = 7'h04;
    localparam logic [6:0] OFF_PR    = 7'h05;
    localparam logic [6:0] OFF_J     = 7'h06;

    // ****************************************
    // reset values and writable masks
    // ****************************************
    localparam logic [7:0] PAGE_RST  = 8'h00;
    localparam logic [7:0] HOME_PAGE = 8'h00;
    localparam logic [7:0] MUX_RST   = 8'h00;
    localparam logic [7:0] MUX_WMASK = 8'h4F;
    localparam logic [7:0] PR_RST    = 8'h11;
    localparam logic [7:0] J_RST     = 8'h04;
    localparam logic [7:0] J_WMASK   = 8'h3F;
    localparam logic [7:0] RSV_READ  = 8'h00;

    // ****************************************
    // field positions and limits
    // ****************************************
    localparam int SWRST_BIT = 0;
    localparam int RANGE_BIT = 6;
    localparam int REF_LSB   = 2;
    localparam int SRC_LSB   = 0;
    localparam int PWR_BIT   = 7;
    localparam int P_LSB     = 4;
    localparam int R_LSB     = 0;
    localparam logic [3:0] R_MIN = 4'h1;
    localparam logic [3:0] R_MAX = 4'h4;
    localparam logic [5:0] J_MIN = 6'h04;
    localparam logic [3:0] P_ZERO_DIV = 4'h8;

endpackage

`default_nettype wire

// ===== src/prcps_regs.sv
`default_nettype none

module prcps_regs (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [6:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    output logic      [7:0] active_page,
    output logic            page_in_range,
    output logic            soft_reset_pulse,
    output logic            pll_high_range,
    output logic      [1:0] pll_ref_sel,
    output logic      [1:0] core_clock_source,
    output logic            pll_power_up,
    output logic      [3:0] pll_p_div,
    output logic      [2:0] pll_r_mult,
    output logic      [5:0] pll_j_mult
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [3:0] p_decode(input logic [2:0] code);
        p_decode = (code == 3'h0) ? prcps_pkg::P_ZERO_DIV
                                  : {1'b0, code};
    endfunction

    function automatic logic r_legal(input logic [3:0] code);
        r_legal = (code >= prcps_pkg::R_MIN)
                  && (code <= prcps_pkg::R_MAX);
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [7:0] page_reg;
    logic [7:0] page_next;
    logic [7:0] mux_reg;
    logic [7:0] mux_next;
    logic [7:0] pr_reg;
    logic [7:0] pr_next;
    logic [7:0] j_reg;
    logic [7:0] j_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       rvalid_reg;
    logic       rvalid_next;
    logic       swrst_reg;
    logic       swrst_next;

    // ****************************************
    // address decode
    // ****************************************
    logic on_home;
    logic hit_page;
    logic hit_swrst;
    logic hit_mux;
    logic hit_pr;
    logic hit_j;
    logic swrst_go;

    // register 0 answers on every page so the host can always leave
    assign on_home   = (page_reg == prcps_pkg::HOME_PAGE);
    assign hit_page  = reg_wr && (reg_addr == prcps_pkg::OFF_PAGE);
    assign hit_swrst = reg_wr && on_home
                       && (reg_addr == prcps_pkg::OFF_SWRST);
    assign hit_mux   = reg_wr && on_home
                       && (reg_addr == prcps_pkg::OFF_MUX);
    assign hit_pr    = reg_wr && on_home
                       && (reg_addr == prcps_pkg::OFF_PR);
    assign hit_j     = reg_wr && on_home
                       && (reg_addr == prcps_pkg::OFF_J);
    // a zero in the reset bit is ignored
    assign swrst_go  = hit_swrst
                       && reg_wdata[prcps_pkg::SWRST_BIT];

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        page_next   = page_reg;
        mux_next    = mux_reg;
        pr_next     = pr_reg;
        j_next      = j_reg;
        rdata_next  = rdata_reg;
        rvalid_next = reg_rd;
        swrst_next  = 1'b0;
        if (reg_rd) begin
            rdata_next = prcps_pkg::RSV_READ;
            if (reg_addr == prcps_pkg::OFF_PAGE) begin
                rdata_next = page_reg;
            end else if (on_home) begin
                case (reg_addr)
                    prcps_pkg::OFF_MUX: rdata_next = mux_reg;
                    prcps_pkg::OFF_PR:  rdata_next = pr_reg;
                    prcps_pkg::OFF_J:   rdata_next = j_reg;
                    default:            rdata_next = prcps_pkg::RSV_READ;
                endcase
            end
        end
        if (hit_page) begin
            page_next = reg_wdata;
        end
        if (hit_mux) begin
            // reserved bits keep their defaults whatever is written
            mux_next = reg_wdata & prcps_pkg::MUX_WMASK;
        end
        if (hit_pr) begin
            pr_next[7:4] = reg_wdata[7:4];
            // an illegal R code would stall the loop; keep the old one
            if (r_legal(reg_wdata[3:0])) begin
                pr_next[3:0] = reg_wdata[3:0];
            end
        end
        if (hit_j && (reg_wdata[5:0] >= prcps_pkg::J_MIN)) begin
            j_next = reg_wdata & prcps_pkg::J_WMASK;
        end
        if (swrst_go) begin
            page_next  = prcps_pkg::PAGE_RST;
            mux_next   = prcps_pkg::MUX_RST;
            pr_next    = prcps_pkg::PR_RST;
            j_next     = prcps_pkg::J_RST;
            swrst_next = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            page_reg   <= prcps_pkg::PAGE_RST;
            mux_reg    <= prcps_pkg::MUX_RST;
            pr_reg     <= prcps_pkg::PR_RST;
            j_reg      <= prcps_pkg::J_RST;
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
            swrst_reg  <= 1'b0;
        end else begin
            page_reg   <= page_next;
            mux_reg    <= mux_next;
            pr_reg     <= pr_next;
            j_reg      <= j_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            swrst_reg  <= swrst_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata         = rdata_reg;
    assign reg_rvalid        = rvalid_reg;
    assign active_page       = page_reg;
    // pages past the last one exist as codes but hold nothing
    assign page_in_range     =
        (page_reg < 8'(prcps_pkg::PAGE_COUNT));
    assign soft_reset_pulse  = swrst_reg;
    assign pll_high_range    = mux_reg[prcps_pkg::RANGE_BIT];
    assign pll_ref_sel       = mux_reg[prcps_pkg::REF_LSB +: 2];
    assign core_clock_source = mux_reg[prcps_pkg::SRC_LSB +: 2];
    assign pll_power_up      = pr_reg[prcps_pkg::PWR_BIT];
    assign pll_p_div         =
        p_decode(pr_reg[prcps_pkg::P_LSB +: 3]);
    assign pll_r_mult        = pr_reg[prcps_pkg::R_LSB +: 3];
    assign pll_j_mult        = j_reg[5:0];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence page_wr_s;
        hit_page && !swrst_go;
    endsequence

    sequence swrst_wr_s;
        swrst_go;
    endsequence

    sequence mux_wr_s;
        hit_mux;
    endsequence

    property page_follows_p;
        page_wr_s |=> (page_reg == $past(reg_wdata));
    endproperty

    property swrst_clears_p;
        swrst_wr_s |=> (page_reg == prcps_pkg::PAGE_RST)
            && (pr_reg == prcps_pkg::PR_RST)
            && (j_reg == prcps_pkg::J_RST)
            && (mux_reg == prcps_pkg::MUX_RST)
            && soft_reset_pulse;
    endproperty

    page_select_a: assert property (page_follows_p)
        else $error("page register did not take written value");

    page_home_a: assert property (
        $rose(rstn) |-> (active_page == prcps_pkg::HOME_PAGE))
        else $error("page not zero after reset");

    swrst_clear_a: assert property (swrst_clears_p)
        else $error("software reset left a register changed");

    swrst_pulse_a: assert property (
        soft_reset_pulse |-> $past(swrst_go))
        else $error("reset pulse without a one written");

    swrst_zero_a: assert property (
        (hit_swrst && !reg_wdata[prcps_pkg::SWRST_BIT])
        |=> !soft_reset_pulse)
        else $error("zero in reset bit fired a reset");

    mux_fields_a: assert property (
        mux_wr_s |=> (core_clock_source == $past(reg_wdata[1:0]))
            && (pll_ref_sel == $past(reg_wdata[3:2]))
            && (pll_high_range == $past(reg_wdata[6])))
        else $error("clock mux fields not updated");

    mux_rsvd_a: assert property (
        (mux_reg & ~prcps_pkg::MUX_WMASK) == 8'h00)
        else $error("reserved mux bits set");

    pll_power_a: assert property (
        hit_pr |=> (pll_power_up == $past(reg_wdata[7])))
        else $error("PLL power bit not updated");

    p_div_a: assert property (
        (hit_pr && (reg_wdata[6:4] == 3'h0))
        |=> (pll_p_div == prcps_pkg::P_ZERO_DIV))
        else $error("P code zero not decoded as eight");

    r_range_a: assert property (
        (pll_r_mult >= 3'h1) && (pll_r_mult <= 3'h4))
        else $error("R multiplier outside one to four");

    j_range_a: assert property (
        pll_j_mult >= prcps_pkg::J_MIN)
        else $error("J multiplier below four");

    read_page_a: assert property (
        (reg_rd && (reg_addr == prcps_pkg::OFF_PAGE))
        |=> reg_rvalid && (reg_rdata == $past(page_reg)))
        else $error("page register read back wrong");

    off_home_a: assert property (
        (reg_rd && !on_home && (reg_addr != prcps_pkg::OFF_PAGE))
        |=> (reg_rdata == prcps_pkg::RSV_READ))
        else $error("page zero register visible on other page");

endmodule

`default_nettype wire

// ===== verif/prcps_host_model.sv
`default_nettype none

module prcps_host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [6:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h55;
        reg_wdata = 8'hA5;
    end

    // ********
    // bus cycle
    // ********
    // a read without its answer returns unknown, so it never matches
    task automatic xfer(input logic rd, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        #1;
        reg_rd = rd;
        reg_wr = !rd;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
        q = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // released lines flip so a stale value never looks live
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic page(input logic [7:0] p);
        logic [7:0] q;
        xfer(1'b0, 7'h00, p, q);
    endtask

    task automatic adc_on();
        logic [7:0] q;
        xfer(1'b0, 7'h12, 8'h81, q);
    endtask
endmodule

`default_nettype wire

// ===== verif/paged_regs_clock_pll_setup_tb.sv
`default_nettype none

module paged_regs_clock_pll_setup_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk;
    logic       rstn;
    logic       reg_wr;
    logic       reg_rd;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic [7:0] active_page;
    logic       page_in_range;
    logic       soft_reset_pulse;
    logic       pll_high_range;
    logic [1:0] pll_ref_sel;
    logic [1:0] core_clock_source;
    logic       pll_power_up;
    logic [3:0] pll_p_div;
    logic [2:0] pll_r_mult;
    logic [5:0] pll_j_mult;
    int         errors;
    int         comparisons;
    logic [7:0] rst_val [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h11, 8'h04};

    prcps_regs uut (
        .core_clk(core_clk), .rstn(rstn), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .active_page(active_page), .page_in_range(page_in_range),
        .soft_reset_pulse(soft_reset_pulse),
        .pll_high_range(pll_high_range), .pll_ref_sel(pll_ref_sel),
        .core_clock_source(core_clock_source),
        .pll_power_up(pll_power_up), .pll_p_div(pll_p_div),
        .pll_r_mult(pll_r_mult), .pll_j_mult(pll_j_mult)
    );

    prcps_host_model host (
        .core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ********
    // checks
    // ********
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic check_read(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] q;
        host.xfer(1'b1, a, ~exp, q);
        comparisons++;
        if (q !== exp) begin
            errors++;
            $display("mismatch at %0t: reg %h read %h", $time, a, q);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(1'b0, a, d, q);
    endtask

    task automatic check_defaults();
        for (int i = 0; i < 7; i++) begin
            check_read(i[6:0], rst_val[i]);
        end
        check(active_page, 8'h00);
        check({4'h0, pll_p_div}, 8'h01);
        check({5'h00, pll_r_mult}, 8'h01);
        check({2'h0, pll_j_mult}, 8'h04);
        check({7'h00, pll_power_up}, 8'h00);
    endtask

    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // whole run needs about 110 cycles, so this is far past it
    initial begin
        #100000;
        errors++;
        final_report();
    end

    initial begin
        errors = 0;
        comparisons = 0;
        rstn = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        check_defaults();
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(7'h04, {1'b0, i[0], 2'b00, i[1:0], ~i[1:0]});
            check({7'h00, pll_high_range}, {7'h00, i[0]});
            check({6'h00, pll_ref_sel}, {6'h00, i[1:0]});
            check({6'h00, core_clock_source}, {6'h00, ~i[1:0]});
        end
        wr(7'h04, 8'hFF);
        check_read(7'h04, 8'h4F);
        $display("test clock mux done");
        // dividers are stepped with the PLL down; the power bit does not gate them
        for (int p = 0; p < 8; p++) begin
            wr(7'h05, {1'b0, p[2:0], 4'(p % 4 + 1)});
            check({4'h0, pll_p_div}, (p == 0) ? 8'h08 : 8'(p));
            check({5'h00, pll_r_mult}, 8'(p % 4 + 1));
            check({7'h00, pll_power_up}, 8'h00);
        end
        wr(7'h05, 8'hF4);
        check({7'h00, pll_power_up}, 8'h01);
        check({4'h0, pll_p_div}, 8'h07);
        wr(7'h05, 8'h74);
        check({7'h00, pll_power_up}, 8'h00);
        wr(7'h05, 8'h20);
        check({4'h0, pll_p_div}, 8'h02);
        check({5'h00, pll_r_mult}, 8'h04);
        check({7'h00, pll_power_up}, 8'h00);
        wr(7'h05, 8'h35);
        check_read(7'h05, 8'h34);
        wr(7'h06, 8'h3F);
        check({2'h0, pll_j_mult}, 8'h3F);
        wr(7'h06, 8'h03);
        check_read(7'h06, 8'h3F);
        wr(7'h06, 8'hC4);
        check_read(7'h06, 8'h04);
        $display("test pll fields done");
        host.page(8'h01);
        check(active_page, 8'h01);
        wr(7'h04, 8'h00);
        check_read(7'h05, 8'h00);
        check_read(7'h00, 8'h01);
        host.page(8'h25);
        check({7'h00, page_in_range}, 8'h01);
        host.page(8'h26);
        check({7'h00, page_in_range}, 8'h00);
        host.page(8'hFF);
        check(active_page, 8'hFF);
        host.page(8'h00);
        check_read(7'h04, 8'h4F);
        $display("test pages done");
        wr(7'h01, 8'h00);
        host.adc_on();
        check_read(7'h04, 8'h4F);
        // move J off its default so the reset is seen to restore it
        wr(7'h06, 8'h3F);
        wr(7'h01, 8'h01);
        check({7'h00, soft_reset_pulse}, 8'h01);
        @(posedge core_clk);
        #1;
        check({7'h00, soft_reset_pulse}, 8'h00);
        check_defaults();
        $display("test soft reset done");
        final_report();
    end
endmodule

`default_nettype wire
